//--- verilog/sfd_pkg.sv
// sfd_pkg: register map, field positions, constants and carriers of the fis data mover
package sfd_pkg;
  // register byte offsets (read and write share some offsets)
  localparam logic [4:0] OFS_TX_BASE = 5'h00;
  localparam logic [4:0] OFS_ERR_CODE = 5'h04;
  localparam logic [4:0] OFS_NDATA_BASE = 5'h04;
  localparam logic [4:0] OFS_CTRL = 5'h08;
  localparam logic [4:0] OFS_RX_COUNT = 5'h0C;
  localparam logic [4:0] OFS_DISK_BASE = 5'h0C;
  localparam logic [4:0] OFS_INT_CLEAR = 5'h10;
  localparam logic [4:0] OFS_INT_STATUS = 5'h14;
  localparam logic [4:0] OFS_INT_MASK = 5'h18;
  // control word fields
  localparam int CTRL_RST_BIT = 31;
  localparam int CTRL_START_BIT = 30;
  localparam int CTRL_TYPE_BIT = 29;
  // interrupt clear fields
  localparam int CLR_RX_BIT = 31;
  localparam int CLR_TX_BIT = 30;
  localparam int CLR_KIND_BIT = 29;
  // received count fields
  localparam int KIND_BIT = 31;
  localparam int CNT_W = 24;
  // interrupt status bits
  localparam int IRQ_TX = 0;
  localparam int IRQ_RX = 1;
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [1:0] RST_IRQ = 2'h0;
  // fis and burst constants
  localparam logic [7:0] FIS_DATA_TYPE = 8'h46;
  localparam logic [31:0] DATA_FIS_HDR = 32'h0000_0046;
  localparam logic [7:0] BURST_LEN = 8'h0F;
  localparam logic [3:0] LAST_BEAT = 4'hF;
  localparam logic [31:0] BURST_BYTES = 32'h0000_0200;
  localparam logic [2:0] AXI_SIZE = 3'h5;
  localparam logic [1:0] AXI_INCR = 2'h1;
  // buffer geometry: 256-bit beats of eight 32-bit words
  localparam int BEAT_W = 256;
  localparam int BUF_D = 32;
  localparam int BUF_AW = 5;
  localparam logic [5:0] BUF_AFULL = 6'h10;
  localparam logic [5:0] BURST_FILL = 6'h10;
  typedef struct packed {
    logic [31:0] addr;
    logic [7:0] len;
    logic valid;
  } sfd_areq_type;
  typedef struct packed {
    logic [31:0] data;
    logic valid;
    logic sof;
    logic eop;
  } sfd_word_type;
endpackage

//--- verilog/sfd_buf.sv
// sfd_buf: synchronous beat buffer with fill count and almost-full flag
`timescale 1ns/1ns
`default_nettype none
module sfd_buf (
  input wire logic clk_i,
  input wire logic clr_i,
  input wire logic push_i,
  input wire logic [sfd_pkg::BEAT_W-1:0] push_data_i,
  input wire logic pop_i,
  output logic [sfd_pkg::BEAT_W-1:0] head_o,
  output logic empty_o,
  output logic full_o,
  output logic afull_o,
  output logic [sfd_pkg::BUF_AW:0] fill_o
);
  import sfd_pkg::*;
  logic [BEAT_W-1:0] mem_q [BUF_D];
  logic [BUF_AW-1:0] wr_q;
  logic [BUF_AW-1:0] rd_q;
  logic [BUF_AW:0] fill_q;
  logic do_push;
  logic do_pop;

  assign do_push = push_i && !full_o;
  assign do_pop = pop_i && !empty_o;

  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem_q[wr_q] <= push_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (clr_i) begin
      wr_q <= '0;
      rd_q <= '0;
      fill_q <= '0;
    end else begin
      if (do_push) begin
        wr_q <= wr_q + 5'h01;
      end
      if (do_pop) begin
        rd_q <= rd_q + 5'h01;
      end
      fill_q <= fill_q + {5'h00, do_push} - {5'h00, do_pop};
    end
  end

  assign head_o = mem_q[rd_q];
  assign empty_o = (fill_q == 6'h00);
  assign full_o = fill_q[BUF_AW];
  assign afull_o = (fill_q > BUF_AFULL);
  assign fill_o = fill_q;
endmodule // sfd_buf
`default_nettype wire

//--- verilog/sfd_dma.sv
// sfd_dma: fis data mover between a link-layer core and an axi4 memory slave
`timescale 1ns/1ns
`default_nettype none
module sfd_dma (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o,
  output var sfd_pkg::sfd_word_type link_tx_o,
  input wire logic link_tx_ready_i,
  input wire sfd_pkg::sfd_word_type link_rx_i,
  output logic link_rx_ready_o,
  output var sfd_pkg::sfd_areq_type ar_o,
  input wire logic arready_i,
  input wire logic [255:0] rdata_i,
  input wire logic rvalid_i,
  input wire logic rlast_i,
  output logic rready_o,
  output var sfd_pkg::sfd_areq_type aw_o,
  input wire logic awready_i,
  output logic [255:0] wdata_o,
  output logic wvalid_o,
  output logic wlast_o,
  input wire logic wready_i,
  input wire logic bvalid_i,
  output logic bready_o
);
  import sfd_pkg::*;
  typedef enum logic [1:0] {AR_IDLE = 2'b00, AR_ADDR = 2'b01, AR_DATA = 2'b11} sfd_ar_type;
  typedef enum logic [1:0] {W_IDLE = 2'b00, W_ADDR = 2'b01, W_DATA = 2'b11, W_RESP = 2'b10} sfd_w_type;
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_RECV = 2'b01, RX_PAD = 2'b11, RX_DRAIN = 2'b10} sfd_rx_type;

  logic wait_q, clr, srst_q, start_q;
  logic [31:0] rdat_q, tx_base_q, nd_base_q, disk_base_q;
  logic [15:0] tx_words_q, sent_q;
  logic tx_type_q, kind_q, irq_q;
  logic [1:0] mask_q, status_q, irq_set;
  logic [CNT_W-1:0] rx_cnt_q;
  logic wr_acc, rd_acc, ctrl_wr, clr_wr;
  sfd_ar_type ar_st_q;
  sfd_w_type w_st_q;
  sfd_rx_type rx_st_q;
  sfd_areq_type ar_q, aw_q;
  sfd_word_type txo_q;
  logic [13:0] beats_left_q;
  logic [16:0] words_rnd;
  logic rready_q, busy_q, hdr_pend_q, hdr_mode_q, first_q;
  logic [2:0] tidx_q, ridx_q;
  logic load, rpop, tx_last;
  logic [255:0] rhead, whead, pack_q, wbeat, wdata_q;
  logic rb_empty, rb_afull, wb_empty, wb_full, wb_afull, wpush, wpop;
  logic [BUF_AW:0] wb_fill;
  logic rx_rdy_q, rx_take, rx_data_q, pkt_start, place;
  logic [3:0] rbeat_q, wbeat_q;
  logic [31:0] wr_addr_q;
  logic wvalid_q, wlast_q, bready_q;

  // avalon slave: one wait cycle, then the access is taken
  assign wr_acc = avs_write_i && !wait_q;
  assign rd_acc = avs_read_i && !wait_q;
  assign ctrl_wr = wr_acc && (avs_address_i == OFS_CTRL);
  assign clr_wr = wr_acc && (avs_address_i == OFS_INT_CLEAR);
  assign clr = !rst_n_i || srst_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wait_q <= 1'b1;
      rdat_q <= RST_WORD;
    end else begin
      wait_q <= !((avs_read_i || avs_write_i) && wait_q);
      if (avs_read_i && wait_q) begin
        unique case (avs_address_i)
          OFS_RX_COUNT: rdat_q <= {kind_q, 7'h00, rx_cnt_q};
          OFS_CTRL: rdat_q <= {1'b0, busy_q, tx_type_q, 13'h0000, tx_words_q};
          OFS_INT_STATUS: rdat_q <= {30'h0000_0000, status_q};
          OFS_INT_MASK: rdat_q <= {30'h0000_0000, mask_q};
          default: rdat_q <= RST_WORD;
        endcase
      end
    end
  end

  // configuration registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tx_base_q <= RST_WORD;
      nd_base_q <= RST_WORD;
      disk_base_q <= RST_WORD;
      tx_words_q <= RST_WORD[15:0];
      tx_type_q <= 1'b0;
      mask_q <= RST_IRQ;
      srst_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      srst_q <= ctrl_wr && avs_writedata_i[CTRL_RST_BIT];
      start_q <= ctrl_wr && avs_writedata_i[CTRL_START_BIT] && !avs_writedata_i[CTRL_RST_BIT];
      if (wr_acc) begin
        unique case (avs_address_i)
          OFS_TX_BASE: tx_base_q <= avs_writedata_i;
          OFS_NDATA_BASE: nd_base_q <= avs_writedata_i;
          OFS_DISK_BASE: disk_base_q <= avs_writedata_i;
          OFS_INT_MASK: mask_q <= avs_writedata_i[1:0];
          OFS_CTRL: begin
            tx_words_q <= avs_writedata_i[15:0];
            tx_type_q <= avs_writedata_i[CTRL_TYPE_BIT];
          end
          default: ;
        endcase
      end
    end
  end

  // interrupt status: set wins over read-clear and clear-register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      status_q <= RST_IRQ;
      irq_q <= 1'b0;
    end else begin
      status_q <= (status_q & ~({2{rd_acc && avs_address_i == OFS_INT_STATUS}}
                  | {clr_wr && avs_writedata_i[CLR_RX_BIT], clr_wr && avs_writedata_i[CLR_TX_BIT]}))
                  | irq_set;
      irq_q <= |(status_q & mask_q);
    end
  end

  // read requests toward memory
  assign words_rnd = {1'b0, tx_words_q} + 17'h00007;
  always_ff @(posedge clk_i) begin
    if (clr) begin
      ar_st_q <= AR_IDLE;
      ar_q <= '0;
      rready_q <= 1'b0;
      beats_left_q <= '0;
    end else if (start_q) begin
      beats_left_q <= words_rnd[16:3];
      ar_q.addr <= tx_base_q;
    end else begin
      unique case (ar_st_q)
        AR_IDLE: if (beats_left_q != 14'h0000 && !rb_afull) begin
          ar_q.valid <= 1'b1;
          ar_q.len <= (beats_left_q > 14'h000F) ? BURST_LEN : beats_left_q[7:0] - 8'h01;
          ar_st_q <= AR_ADDR;
        end
        AR_ADDR: if (arready_i) begin
          ar_q.valid <= 1'b0;
          rready_q <= 1'b1;
          ar_st_q <= AR_DATA;
        end
        AR_DATA: if (rvalid_i && rlast_i) begin
          rready_q <= 1'b0;
          beats_left_q <= beats_left_q - {6'h00, ar_q.len} - 14'h0001;
          ar_q.addr <= ar_q.addr + BURST_BYTES;
          ar_st_q <= AR_IDLE;
        end
        default: ar_st_q <= AR_IDLE;
      endcase
    end
  end

  sfd_buf u_read_side_buffer (
    .clk_i(clk_i),
    .clr_i(clr),
    .push_i(rvalid_i && rready_q),
    .push_data_i(rdata_i),
    .pop_i(rpop),
    .head_o(rhead),
    .empty_o(rb_empty),
    .full_o(),
    .afull_o(rb_afull),
    .fill_o()
  );

  // send side: 256-bit beat unpacked into 32-bit link words
  assign load = !txo_q.valid || link_tx_ready_i;
  assign tx_last = (sent_q + 16'h0001 == tx_words_q);
  assign rpop = busy_q && !hdr_pend_q && !rb_empty && load && (tidx_q == 3'h7 || tx_last);

  always_ff @(posedge clk_i) begin
    if (clr) begin
      txo_q <= '0;
      busy_q <= 1'b0;
      hdr_pend_q <= 1'b0;
      hdr_mode_q <= 1'b0;
      first_q <= 1'b0;
      sent_q <= '0;
      tidx_q <= '0;
    end else if (start_q) begin
      busy_q <= (tx_words_q != 16'h0000);
      hdr_pend_q <= tx_type_q && (tx_words_q != 16'h0000);
      hdr_mode_q <= tx_type_q;
      first_q <= 1'b1;
      sent_q <= '0;
      tidx_q <= '0;
    end else if (load) begin
      if (busy_q && hdr_pend_q) begin
        txo_q <= '{data: DATA_FIS_HDR, valid: 1'b1, sof: 1'b1, eop: 1'b0};
        hdr_pend_q <= 1'b0;
        first_q <= 1'b0;
      end else if (busy_q && !rb_empty) begin
        txo_q <= '{data: rhead[tidx_q*32 +: 32], valid: 1'b1, sof: first_q, eop: tx_last};
        first_q <= 1'b0;
        sent_q <= sent_q + 16'h0001;
        tidx_q <= tx_last ? 3'h0 : tidx_q + 3'h1;
        busy_q <= !tx_last;
      end else begin
        txo_q <= '0;
      end
    end
  end

  // receive side: decode, strip data header, pack words, pad to burst
  assign rx_take = link_rx_i.valid && rx_rdy_q;
  assign pkt_start = rx_take && rx_st_q == RX_IDLE;
  assign place = rx_take && !(pkt_start && link_rx_i.data[7:0] == FIS_DATA_TYPE);
  always_comb begin
    wbeat = pack_q;
    wpush = 1'b0;
    if (place) begin
      wbeat[ridx_q*32 +: 32] = link_rx_i.data;
      wpush = (ridx_q == 3'h7);
    end else if (rx_st_q == RX_PAD) begin
      wpush = (ridx_q != 3'h0 || rbeat_q != 4'h0) && !wb_full;
    end
  end

  always_ff @(posedge clk_i) begin
    if (clr) begin
      rx_st_q <= RX_IDLE;
      rx_rdy_q <= 1'b0;
      rx_data_q <= 1'b0;
      pack_q <= '0;
      ridx_q <= '0;
      rbeat_q <= '0;
    end else begin
      rx_rdy_q <= (rx_st_q == RX_IDLE || rx_st_q == RX_RECV) && !wb_afull && !(rx_take && link_rx_i.eop);
      if (wpush) begin
        pack_q <= '0;
        ridx_q <= '0;
        rbeat_q <= rbeat_q + 4'h1;
      end else if (place) begin
        pack_q <= wbeat;
        ridx_q <= ridx_q + 3'h1;
      end
      unique case (rx_st_q)
        RX_IDLE: if (rx_take) begin
          rx_data_q <= (link_rx_i.data[7:0] == FIS_DATA_TYPE);
          rx_st_q <= link_rx_i.eop ? RX_PAD : RX_RECV;
        end
        RX_RECV: if (rx_take && link_rx_i.eop) begin
          rx_st_q <= RX_PAD;
        end
        RX_PAD: if (!wpush && ridx_q == 3'h0 && rbeat_q == 4'h0) begin
          rx_st_q <= RX_DRAIN;
        end
        RX_DRAIN: if (wb_empty && w_st_q == W_IDLE) begin
          rx_st_q <= RX_IDLE;
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // received count and kind
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rx_cnt_q <= '0;
      kind_q <= 1'b0;
    end else begin
      if (pkt_start) begin
        rx_cnt_q <= 24'h000001;
      end else if (rx_take) begin
        rx_cnt_q <= rx_cnt_q + 24'h000001;
      end else if (ctrl_wr) begin
        rx_cnt_q <= '0;
      end
      if (pkt_start) begin
        kind_q <= (link_rx_i.data[7:0] != FIS_DATA_TYPE);
      end else if (clr_wr && avs_writedata_i[CLR_KIND_BIT]) begin
        kind_q <= 1'b0;
      end
    end
  end

  assign irq_set[IRQ_TX] = txo_q.valid && txo_q.eop && link_tx_ready_i;
  assign irq_set[IRQ_RX] = rx_st_q == RX_DRAIN && wb_empty && w_st_q == W_IDLE;

  sfd_buf u_write_side_buffer (
    .clk_i(clk_i),
    .clr_i(clr),
    .push_i(wpush),
    .push_data_i(wbeat),
    .pop_i(wpop),
    .head_o(whead),
    .empty_o(wb_empty),
    .full_o(wb_full),
    .afull_o(wb_afull),
    .fill_o(wb_fill)
  );

  // write bursts toward memory
  assign wpop = (w_st_q == W_ADDR && awready_i) || (w_st_q == W_DATA && wready_i && wbeat_q != LAST_BEAT);
  always_ff @(posedge clk_i) begin
    if (clr) begin
      w_st_q <= W_IDLE;
      aw_q <= '0;
      wr_addr_q <= '0;
      wdata_q <= '0;
      wvalid_q <= 1'b0;
      wlast_q <= 1'b0;
      bready_q <= 1'b0;
      wbeat_q <= '0;
    end else begin
      if (pkt_start) begin
        wr_addr_q <= (link_rx_i.data[7:0] == FIS_DATA_TYPE) ? disk_base_q : nd_base_q;
      end
      unique case (w_st_q)
        W_IDLE: if (wb_fill >= BURST_FILL) begin
          aw_q <= '{addr: wr_addr_q, len: BURST_LEN, valid: 1'b1};
          w_st_q <= W_ADDR;
        end
        W_ADDR: if (awready_i) begin
          aw_q.valid <= 1'b0;
          wdata_q <= whead;
          wvalid_q <= 1'b1;
          wbeat_q <= '0;
          w_st_q <= W_DATA;
        end
        W_DATA: if (wready_i) begin
          if (wbeat_q == LAST_BEAT) begin
            wvalid_q <= 1'b0;
            wlast_q <= 1'b0;
            bready_q <= 1'b1;
            w_st_q <= W_RESP;
          end else begin
            wdata_q <= whead;
            wbeat_q <= wbeat_q + 4'h1;
            wlast_q <= (wbeat_q == LAST_BEAT - 4'h1);
          end
        end
        W_RESP: if (bvalid_i) begin
          bready_q <= 1'b0;
          wr_addr_q <= wr_addr_q + BURST_BYTES;
          w_st_q <= W_IDLE;
        end
        default: w_st_q <= W_IDLE;
      endcase
    end
  end

  assign avs_readdata_o = rdat_q;
  assign avs_waitrequest_o = wait_q;
  assign irq_o = irq_q;
  assign link_tx_o = txo_q;
  assign link_rx_ready_o = rx_rdy_q;
  assign ar_o = ar_q;
  assign rready_o = rready_q;
  assign aw_o = aw_q;
  assign wdata_o = wdata_q;
  assign wvalid_o = wvalid_q;
  assign wlast_o = wlast_q;
  assign bready_o = bready_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (clr);
  ar_pause_a: assert property (ar_st_q == AR_IDLE && rb_afull && !start_q |=> !ar_q.valid) else $error("read request while buffer almost full");
  rd_pop_a: assert property (rpop |-> !rb_empty && load) else $error("read buffer popped without room");
  hdr_lead_a: assert property (txo_q.valid && txo_q.sof && hdr_mode_q |-> txo_q.data == DATA_FIS_HDR) else $error("data header missing");
  eop_count_a: assert property (txo_q.valid && txo_q.eop |-> sent_q == tx_words_q) else $error("eop at wrong count");
  eop_valid_a: assert property (txo_q.eop |-> txo_q.valid) else $error("eop on idle cycle");
  hdr_drop_a: assert property (pkt_start && link_rx_i.data[7:0] == FIS_DATA_TYPE |=> ridx_q == 3'h0) else $error("data header stored");
  burst_len_a: assert property (wvalid_q && wready_i && wlast_q |-> wbeat_q == LAST_BEAT) else $error("burst not 16 beats");
  burst_fill_a: assert property ($rose(aw_q.valid) |-> $past(wb_fill) >= BURST_FILL) else $error("burst without full data");
  w_idle_a: assert property (w_st_q == W_RESP && bvalid_i |=> w_st_q == W_IDLE ##1 (w_st_q != W_DATA)) else $error("no idle after burst");
  rx_irq_a: assert property (irq_set[IRQ_RX] |=> status_q[IRQ_RX] ##1 (irq_q || !$past(mask_q[IRQ_RX]))) else $error("rx done not flagged");
endmodule // sfd_dma
`default_nettype wire

//--- test/sfd_mem_model.sv
// sfd_mem_model: axi4 memory slave model on the far side of the fis data mover
`timescale 1ns/1ns
`default_nettype none
module sfd_mem_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire sfd_pkg::sfd_areq_type ar_i,
  output logic arready_o,
  output logic [255:0] rdata_o,
  output logic rvalid_o,
  output logic rlast_o,
  input wire logic rready_i,
  input wire sfd_pkg::sfd_areq_type aw_i,
  output logic awready_o,
  input wire logic [255:0] wdata_i,
  input wire logic wvalid_i,
  input wire logic wlast_i,
  output logic wready_o,
  output logic bvalid_o,
  input wire logic bready_i
);
  import sfd_pkg::*;
  logic [255:0] wmem [128];
  logic [6:0] ridx;
  logic [6:0] widx;
  logic [7:0] rrem;
  logic [3:0] wbeat;
  logic [31:0] aw_last;
  int bursts;
  int werr;
  int rerr;
  // beat contents: word j of beat i reads as c000_0000 + i*8 + j
  function automatic logic [255:0] pat(input logic [6:0] i);
    for (int j = 0; j < 8; j++) begin
      pat[j*32 +: 32] = 32'hC000_0000 + {i, 3'(j)};
    end
  endfunction
  // read channel: one burst at a time, data inverted once released
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      arready_o <= 1'b0;
      rvalid_o <= 1'b0;
      rlast_o <= 1'b0;
      rerr <= 0;
    end else begin
      arready_o <= ar_i.valid && !arready_o && !rvalid_o;
      if (ar_i.valid && arready_o) begin
        ridx <= ar_i.addr[11:5];
        rrem <= ar_i.len;
        rerr <= rerr + int'(ar_i.len > BURST_LEN);
        rvalid_o <= 1'b1;
        rdata_o <= pat(ar_i.addr[11:5]);
        rlast_o <= (ar_i.len == 8'h00);
      end else if (rvalid_o && rready_i) begin
        rvalid_o <= (rrem != 8'h00);
        ridx <= ridx + 7'h01;
        rrem <= rrem - 8'h01;
        rdata_o <= (rrem != 8'h00) ? pat(ridx + 7'h01) : ~rdata_o;
        rlast_o <= (rrem == 8'h01);
      end
    end
  end
  // write channel: address, sixteen beats, then response held until taken
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      awready_o <= 1'b0;
      wready_o <= 1'b0;
      bvalid_o <= 1'b0;
      bursts <= 0;
      werr <= 0;
    end else begin
      awready_o <= aw_i.valid && !awready_o && !wready_o && !bvalid_o;
      if (aw_i.valid && awready_o) begin
        widx <= aw_i.addr[11:5];
        aw_last <= aw_i.addr;
        werr <= werr + int'(aw_i.len != BURST_LEN);
        wready_o <= 1'b1;
        wbeat <= 4'h0;
      end
      if (wvalid_i && wready_o) begin
        wmem[widx + 7'(wbeat)] <= wdata_i;
        wbeat <= wbeat + 4'h1;
        werr <= werr + int'(wlast_i != (wbeat == LAST_BEAT));
        if (wlast_i) begin
          wready_o <= 1'b0;
          bvalid_o <= 1'b1;
          bursts <= bursts + 1;
        end
      end
      if (bvalid_o && bready_i) begin
        bvalid_o <= 1'b0;
      end
    end
  end
endmodule // sfd_mem_model
`default_nettype wire

//--- test/tb_sfd_dma.sv
// tb_sfd_dma: self-checking testbench of the fis data mover
`timescale 1ns/1ns
`default_nettype none
module tb_sfd_dma;
  import sfd_pkg::*;
  logic clk, rst_n, avs_read, avs_write, waitrequest, irq, tx_ready, rx_ready;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, readdata;
  sfd_word_type tx, rx;
  sfd_areq_type ar, aw;
  logic arready, rvalid, rlast, rready, awready, wvalid, wlast, wready, bvalid, bready;
  logic [255:0] rdata, wdata;
  int fails, n_tests;
  sfd_dma dut (.clk_i(clk), .rst_n_i(rst_n), .avs_address_i(avs_address), .avs_read_i(avs_read),
    .avs_write_i(avs_write), .avs_writedata_i(avs_writedata), .avs_readdata_o(readdata),
    .avs_waitrequest_o(waitrequest), .irq_o(irq), .link_tx_o(tx), .link_tx_ready_i(tx_ready),
    .link_rx_i(rx), .link_rx_ready_o(rx_ready), .ar_o(ar), .arready_i(arready), .rdata_i(rdata),
    .rvalid_i(rvalid), .rlast_i(rlast), .rready_o(rready), .aw_o(aw), .awready_i(awready),
    .wdata_o(wdata), .wvalid_o(wvalid), .wlast_o(wlast), .wready_i(wready), .bvalid_i(bvalid),
    .bready_o(bready));
  sfd_mem_model mem (.clk_i(clk), .rst_n_i(rst_n), .ar_i(ar), .arready_o(arready), .rdata_o(rdata),
    .rvalid_o(rvalid), .rlast_o(rlast), .rready_i(rready), .aw_i(aw), .awready_o(awready),
    .wdata_i(wdata), .wvalid_i(wvalid), .wlast_i(wlast), .wready_o(wready), .bvalid_o(bvalid),
    .bready_i(bready));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons=%0d mismatches=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic t_reset;
    logic [4:0] ofs [6] = '{OFS_CTRL, OFS_RX_COUNT, OFS_INT_STATUS, OFS_INT_MASK, OFS_ERR_CODE, 5'h1C};
    logic [31:0] v;
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, ofs[i], 32'h0, v);
      check(v, RST_WORD);
    end
    check(irq, 1'b0);
    bus(1'b1, OFS_TX_BASE, 32'h0000_0000, v);
    bus(1'b1, OFS_NDATA_BASE, 32'h0000_0C00, v);
    bus(1'b1, OFS_DISK_BASE, 32'h0000_0400, v);
    $display("reset test done");
  endtask
  task automatic t_send(input logic hdr, input int n);
    logic [31:0] v;
    int got, c;
    got = 0;
    bus(1'b1, OFS_CTRL, {1'b0, 1'b1, hdr, 13'h0, 16'(n)}, v);
    for (c = 0; c < 3000 && (got < n + hdr || c < 40); c++) begin
      @(posedge clk);
      if (tx.valid === 1'b1 && tx_ready === 1'b1) begin
        check(tx.sof, got == 0);
        if (hdr && got == 0) check(tx.data, DATA_FIS_HDR);
        else check(tx.data, 32'hC000_0000 + got - hdr);
        check(tx.eop, got == n + hdr - 1);
        got++;
      end else if (tx.valid === 1'b0) check(tx.eop, 1'b0);
      tx_ready <= (c % 3 != 0);
    end
    check(got, n + hdr);
    check(mem.rerr, 0);
    bus(1'b0, OFS_INT_STATUS, 32'h0, v);
    check(v, n != 0);
    $display("send test done");
  endtask
  task automatic t_recv(input logic [31:0] hd, input int n, input logic [31:0] base, input int nb, input logic msk);
    logic [31:0] v, e;
    logic dat;
    int i, k, w, b0, s;
    int ws [5];
    dat = (hd[7:0] == FIS_DATA_TYPE);
    s = n + !dat;
    ws = '{0, 1, s - 1, s, nb * 128 - 1};
    b0 = mem.bursts;
    bus(1'b1, OFS_INT_MASK, {30'h0, msk, 1'b1}, v);
    for (i = 0; i <= n; i++) begin
      rx <= '{data: (i == 0) ? hd : 32'hE000_0000 + i, valid: 1'b1, sof: i == 0, eop: i == n};
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (rx_ready !== 1'b1 && k < 100);
      if (k >= 100) fails++;
    end
    rx <= '{data: ~rx.data, valid: 1'b0, sof: 1'b0, eop: 1'b0};
    for (k = 0; k < 2000 && mem.bursts != b0 + nb; k++) @(posedge clk);
    repeat (4) @(posedge clk);
    check(mem.bursts - b0, nb);
    check(mem.werr, 0);
    check(mem.aw_last, base + (nb - 1) * 512);
    for (i = 0; i < 5; i++) begin
      w = ws[i];
      e = (w >= s) ? 32'h0 : (!dat && w == 0) ? hd : 32'hE000_0000 + w + dat;
      check(mem.wmem[7'(base[11:5] + w / 8)][w % 8 * 32 +: 32], e);
    end
    check(irq, msk);
    bus(1'b0, OFS_INT_STATUS, 32'h0, v);
    check(v, 32'h2);
    bus(1'b0, OFS_RX_COUNT, 32'h0, v);
    check(v, {!dat, 7'h0, 24'(n + 1)});
    check(irq, 1'b0);
    bus(1'b1, OFS_INT_CLEAR, 32'h2000_0000, v);
    bus(1'b0, OFS_RX_COUNT, 32'h0, v);
    check(v, {8'h0, 24'(n + 1)});
    bus(1'b1, OFS_CTRL, 32'h8000_0000, v);
    bus(1'b0, OFS_RX_COUNT, 32'h0, v);
    check(v, 32'h0);
    bus(1'b0, OFS_INT_MASK, 32'h0, v);
    check(v, {30'h0, msk, 1'b1});
    $display("receive test done");
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #(30000 * 50);
    fails++;
    print_verdict;
  end
  initial begin
    rst_n = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    tx_ready = 1'b0;
    rx = '0;
    fails = 0;
    n_tests = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_send(1'b1, 300);
    t_send(1'b0, 1);
    t_send(1'b0, 0);
    t_recv(DATA_FIS_HDR, 129, 32'h0000_0400, 2, 1'b1);
    t_recv(32'h0000_0034, 4, 32'h0000_0C00, 1, 1'b0);
    print_verdict;
  end
endmodule // tb_sfd_dma
`default_nettype wire
